/* rtl/rsl_consts.vh */
// constants for the reference select and loss control block
`ifndef RSL_CONSTS_VH
`define RSL_CONSTS_VH
// register byte offsets
`define RSL_ADDR_CFG 12'h000
`define RSL_ADDR_DIV 12'h004
`define RSL_ADDR_STAT 12'h008
`define RSL_ADDR_TUNE 12'h00C
// configuration and divider word fields
`define RSL_CFG_SEL_LSB 0
`define RSL_CFG_KIND_LSB 2
`define RSL_CFG_TMO_LSB 4
`define RSL_CFG_FMT_LSB 6
`define RSL_CFG_WAIT_BIT 8
`define RSL_DIV_N_LSB 0
`define RSL_DIV_R_LSB 16
// reset values
`define RSL_CFG_RST 9'h000
`define RSL_DIV_RST 12'h001
// selection modes
`define RSL_SEL_FORCE0 2'h0
`define RSL_SEL_FORCE1 2'h1
`define RSL_SEL_NONREV 2'h2
`define RSL_SEL_REV 2'h3
// loss pin formats
`define RSL_FMT_NMOS 2'h1
`define RSL_FMT_PMOS 2'h2
`define RSL_FMT_CMOS 2'h3
// minimum detectable input frequencies in kHz
`define RSL_FMIN0_KHZ 1000
`define RSL_FMIN1_KHZ 3000
`define RSL_FMIN2_KHZ 13000
`define RSL_FMIN3_KHZ 32000
// sampling clock in kHz
`define RSL_CLK_KHZ 20000
// shortest loss window in clock cycles
`define RSL_WIN_MIN 1
// htrans and hsize codes
`define RSL_HTRANS_NONSEQ 2'h2
`define RSL_HSIZE_WORD 3'h2
`endif

/* rtl/rsl_loss_det.v */
// loss-of-signal detector for one reference input
`include "rsl_consts.vh"
`default_nettype none
module rsl_loss_det #(
   parameter CW = 8
)
(
   input wire clk,
   input wire rst_n,
   input wire ref_in,
   input wire [CW-1:0] window,
   output reg lost_q
);
   reg [2:0] sync_q;
   reg [CW-1:0] cnt_q;
   wire edge_seen;

   assign edge_seen = sync_q[1] ^ sync_q[2];

   // watchdog restarts on every edge; expiry flags loss
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_q <= 3'h0;
         cnt_q <= {CW{1'b0}};
         lost_q <= 1'b1;
      end
      else
      begin
         sync_q <= {sync_q[1:0], ref_in};
         if (edge_seen)
         begin
            cnt_q <= {CW{1'b0}};
            lost_q <= 1'b0;
         end
         else if (cnt_q >= window)
            lost_q <= 1'b1;
         else
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

/* rtl/rsl_divider.v */
// 12-bit programmable divider counter
`include "rsl_consts.vh"
`default_nettype none
module rsl_divider #(
   parameter W = 12
)
(
   input wire clk,
   input wire rst_n,
   input wire in_tick,
   input wire [W-1:0] ratio,
   output reg out_tick_q
);
   reg [W-1:0] cnt_q;

   // one output tick per ratio input ticks; zero ratio holds off
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= {W{1'b0}};
         out_tick_q <= 1'b0;
      end
      else
      begin
         out_tick_q <= 1'b0;
         if (ratio == {W{1'b0}})
            cnt_q <= {W{1'b0}};
         else if (in_tick)
         begin
            if (cnt_q >= ratio - {{(W-1){1'b0}}, 1'b1})
            begin
               cnt_q <= {W{1'b0}};
               out_tick_q <= 1'b1;
            end
            else
               cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/rsl_ref_ctrl.v */
// reference selection, loss control, dividers and tune gating
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`include "rsl_consts.vh"
`default_nettype none
module rsl_ref_ctrl #(
   parameter DW = 12,
   parameter CW = 8
)
(
   input wire clk,
   input wire rst_n,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire ref_input_0,
   input wire ref_input_1,
   input wire cleaner_lock_detect,
   input wire synth_n_update,
   output reg ref_select_q,
   output reg [1:0] input_buffer_kind_q,
   output reg cleaner_ref_tick_q,
   output reg cleaner_fb_tick_q,
   input wire osc_tick,
   output reg tune_start_q,
   output reg input0_loss_indicator_o,
   output reg input0_loss_indicator_oe,
   output reg input1_loss_indicator_o,
   output reg input1_loss_indicator_oe
);
   localparam ST_FORCED = 3'b001;
   localparam ST_AUTO0 = 3'b010;
   localparam ST_AUTO1 = 3'b100;

   function [CW-1:0] win_cycles;
      input [1:0] code;
      integer w;
      begin
         // longest gap without an edge: half a period, rounded down
         case (code)
            2'h0: w = `RSL_CLK_KHZ / (2 * `RSL_FMIN0_KHZ);
            2'h1: w = `RSL_CLK_KHZ / (2 * `RSL_FMIN1_KHZ);
            2'h2: w = `RSL_CLK_KHZ / (2 * `RSL_FMIN2_KHZ);
            default: w = `RSL_CLK_KHZ / (2 * `RSL_FMIN3_KHZ);
         endcase
         // clock too slow to resolve these: one cycle is the floor
         if (w < `RSL_WIN_MIN)
            w = `RSL_WIN_MIN;
         win_cycles = w[CW-1:0];
      end
   endfunction

   function in_auto;
      input [1:0] sel;
      begin
         in_auto = sel[1];
      end
   endfunction

   reg [8:0] cfg_q;
   reg [DW-1:0] div_n_q;
   reg [DW-1:0] div_r_q;
   reg tune_pend_q;
   reg [2:0] st_q;
   reg [2:0] st_d;
   reg sel_d;
   reg wr_pend_q;
   reg [11:0] wr_addr_q;
   reg [2:0] ref_sync_q;
   wire [1:0] sel_mode;
   wire [1:0] fmt;
   wire lost0;
   wire lost1;
   wire [CW-1:0] window;
   wire ref_rise;
   wire fb_tick;
   wire n_tick;
   wire addr_ok;

   assign sel_mode = cfg_q[`RSL_CFG_SEL_LSB +: 2];
   assign fmt = cfg_q[`RSL_CFG_FMT_LSB +: 2];
   assign window = win_cycles(cfg_q[`RSL_CFG_TMO_LSB +: 2]);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ok = hsel && hready && (htrans == `RSL_HTRANS_NONSEQ);

   rsl_loss_det #(.CW(CW)) u_los0 (
      .clk(clk),
      .rst_n(rst_n),
      .ref_in(ref_input_0),
      .window(window),
      .lost_q(lost0)
   );

   rsl_loss_det #(.CW(CW)) u_los1 (
      .clk(clk),
      .rst_n(rst_n),
      .ref_in(ref_input_1),
      .window(window),
      .lost_q(lost1)
   );

   // bus write capture and register file
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         cfg_q <= `RSL_CFG_RST;
         div_n_q <= `RSL_DIV_RST;
         div_r_q <= `RSL_DIV_RST;
         input_buffer_kind_q <= 2'h0;
      end
      else
      begin
         wr_pend_q <= addr_ok && hwrite && (hsize == `RSL_HSIZE_WORD);
         wr_addr_q <= haddr;
         input_buffer_kind_q <= cfg_q[`RSL_CFG_KIND_LSB +: 2];
         if (wr_pend_q)
         begin
            case (wr_addr_q)
               `RSL_ADDR_CFG: cfg_q <= hwdata[8:0];
               `RSL_ADDR_DIV:
               begin
                  div_n_q <= hwdata[`RSL_DIV_N_LSB +: DW];
                  div_r_q <= hwdata[`RSL_DIV_R_LSB +: DW];
               end
               default: ;
            endcase
         end
      end
   end

   // read data registered in the address phase
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         hrdata <= 32'h00000000;
      else if (addr_ok && !hwrite)
      begin
         case (haddr)
            `RSL_ADDR_CFG: hrdata <= {23'h000000, cfg_q};
            `RSL_ADDR_DIV: hrdata <= {4'h0, div_r_q, 4'h0, div_n_q};
            `RSL_ADDR_STAT: hrdata <= {28'h0000000, tune_pend_q,
               ref_select_q, lost1, lost0};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // selection state machine
   always @*
   begin
      st_d = st_q;
      sel_d = ref_select_q;
      case (st_q)
         ST_FORCED:
         begin
            sel_d = (sel_mode == `RSL_SEL_FORCE1);
            if (in_auto(sel_mode))
            begin
               st_d = ST_AUTO0;
               sel_d = 1'b0;
            end
         end
         ST_AUTO0:
         begin
            sel_d = 1'b0;
            if (!in_auto(sel_mode))
               st_d = ST_FORCED;
            else if (lost0 && !lost1)
            begin
               st_d = ST_AUTO1;
               sel_d = 1'b1;
            end
         end
         ST_AUTO1:
         begin
            sel_d = 1'b1;
            if (!in_auto(sel_mode))
               st_d = ST_FORCED;
            else if ((sel_mode == `RSL_SEL_REV && !lost0) ||
                     (sel_mode == `RSL_SEL_NONREV && lost1))
            begin
               st_d = ST_AUTO0;
               sel_d = 1'b0;
            end
         end
         default:
         begin
            st_d = ST_FORCED;
            sel_d = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= ST_FORCED;
         ref_select_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         ref_select_q <= sel_d;
      end
   end

   // loss pins: driven only in auto modes, per format
   always @*
   begin
      input0_loss_indicator_o = lost0;
      input1_loss_indicator_o = lost1;
      input0_loss_indicator_oe = 1'b0;
      input1_loss_indicator_oe = 1'b0;
      if (in_auto(sel_mode))
      begin
         case (fmt)
            `RSL_FMT_NMOS:
            begin
               input0_loss_indicator_o = 1'b0;
               input1_loss_indicator_o = 1'b0;
               input0_loss_indicator_oe = !lost0;
               input1_loss_indicator_oe = !lost1;
            end
            `RSL_FMT_PMOS:
            begin
               input0_loss_indicator_o = 1'b1;
               input1_loss_indicator_o = 1'b1;
               input0_loss_indicator_oe = lost0;
               input1_loss_indicator_oe = lost1;
            end
            `RSL_FMT_CMOS:
            begin
               input0_loss_indicator_oe = 1'b1;
               input1_loss_indicator_oe = 1'b1;
            end
            default: ;
         endcase
      end
   end

   // selected reference edge feeds the reference divider
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_sync_q <= 3'h0;
      end
      else
      begin
         ref_sync_q <= {ref_sync_q[1:0],
            ref_select_q ? ref_input_1 : ref_input_0};
      end
   end
   assign ref_rise = ref_sync_q[1] && !ref_sync_q[2];

   rsl_divider #(.W(DW)) u_rdiv (
      .clk(clk),
      .rst_n(rst_n),
      .in_tick(ref_rise),
      .ratio(div_r_q),
      .out_tick_q(fb_tick)
   );

   rsl_divider #(.W(DW)) u_ndiv (
      .clk(clk),
      .rst_n(rst_n),
      .in_tick(osc_tick),
      .ratio(div_n_q),
      .out_tick_q(n_tick)
   );

   // dividers run regardless of tune gating
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cleaner_ref_tick_q <= 1'b0;
         cleaner_fb_tick_q <= 1'b0;
      end
      else
      begin
         cleaner_ref_tick_q <= fb_tick;
         cleaner_fb_tick_q <= n_tick;
      end
   end

   // tune trigger after each synth feedback update
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tune_pend_q <= 1'b0;
         tune_start_q <= 1'b0;
      end
      else
      begin
         tune_start_q <= 1'b0;
         if (synth_n_update || tune_pend_q)
         begin
            if (!cfg_q[`RSL_CFG_WAIT_BIT] || cleaner_lock_detect)
            begin
               tune_start_q <= 1'b1;
               tune_pend_q <= 1'b0;
            end
            else
               tune_pend_q <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* sim/rsl_ref_ctrl_chk.sv */
// port assertions for the reference select block
`default_nettype none
module rsl_ref_ctrl_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic cleaner_lock_detect,
   input wire logic synth_n_update,
   input wire logic osc_tick,
   input wire logic cleaner_fb_tick_q,
   input wire logic ref_select_q,
   input wire logic tune_start_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wire logic rd_a = hsel && hready && htrans == 2'h2 && !hwrite;
   property p_rdy;
      hreadyout && !hresp;
   endproperty
   a_rdy: assert property (p_rdy) else $error("bus stalled or error");
   property p_rsvd;
      rd_a && haddr == 12'h00C |=> hrdata == 32'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
   property p_hold;
      !rd_a |=> $stable(hrdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_stat;
      rd_a && haddr == 12'h008 |=> hrdata[2] == $past(ref_select_q);
   endproperty
   a_stat: assert property (p_stat) else $error("status select wrong");
   property p_cause;
      tune_start_q |-> $past(synth_n_update) || $past(cleaner_lock_detect);
   endproperty
   a_cause: assert property (p_cause) else $error("tune without cause");
   property p_now;
      synth_n_update && cleaner_lock_detect |=> tune_start_q;
   endproperty
   a_now: assert property (p_now) else $error("tune missing");
   property p_pulse;
      tune_start_q && !synth_n_update |=> !tune_start_q;
   endproperty
   a_pulse: assert property (p_pulse) else $error("tune pulse too long");
   property p_fb;
      cleaner_fb_tick_q |-> $past(osc_tick, 2);
   endproperty
   a_fb: assert property (p_fb) else $error("feedback tick no input");
   c_tune: cover property (tune_start_q);
   c_sw: cover property ($rose(ref_select_q));
   c_fb: cover property (cleaner_fb_tick_q);
endmodule
bind rsl_ref_ctrl rsl_ref_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .cleaner_lock_detect(cleaner_lock_detect),
   .synth_n_update(synth_n_update), .osc_tick(osc_tick),
   .cleaner_fb_tick_q(cleaner_fb_tick_q), .ref_select_q(ref_select_q),
   .tune_start_q(tune_start_q));
`default_nettype wire

/* sim/rsl_ref_src.sv */
// two reference clock sources that can be stopped
`default_nettype none
module rsl_ref_src (
   input wire logic run0,
   input wire logic run1,
   output logic ref0,
   output logic ref1
);
   timeunit 1ns;
   timeprecision 1ns;
   // stopped source stands low, edges cease
   initial
   begin
      ref0 = 1'h0;
      forever #110 ref0 = run0 ? !ref0 : 1'h0;
   end
   initial
   begin
      ref1 = 1'h0;
      forever #135 ref1 = run1 ? !ref1 : 1'h0;
   end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the reference select block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, hsel, hwrite, lock, upd, osc, run0, run1, ref0, ref1;
   logic [11:0] haddr;
   logic [1:0] htrans, kind;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   wire logic rdy, resp, sel, rtk, ftk, tune, o0, e0, o1, e1;
   int n_fail, comparisons, i, n;
   rsl_ref_src src (.run0(run0), .run1(run1), .ref0(ref0), .ref1(ref1));
   rsl_ref_ctrl DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(resp),
      .hrdata(hrdata), .ref_input_0(ref0), .ref_input_1(ref1),
      .cleaner_lock_detect(lock), .synth_n_update(upd),
      .ref_select_q(sel), .input_buffer_kind_q(kind),
      .cleaner_ref_tick_q(rtk), .cleaner_fb_tick_q(ftk), .osc_tick(osc),
      .tune_start_q(tune), .input0_loss_indicator_o(o0),
      .input0_loss_indicator_oe(e0), .input1_loss_indicator_o(o1),
      .input1_loss_indicator_oe(e1));
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic hwait;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rdy !== 1'h1 && n < 50);
      if (n >= 50)
      begin
         n_fail++;
         stop_test();
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hwait();
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      hwait();
      rd = hrdata;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a,
      input logic [31:0] exp);
      bus(1'h0, a, 32'h0);
      chk(nm, rd, exp);
   endtask
   task automatic wcfg(input logic [8:0] v);
      bus(1'h1, 12'h000, {23'h0, v});
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wsel(input logic e);
      i = 0;
      while (sel !== e && i < 80)
      begin
         @(negedge clk);
         i++;
      end
      chk("select", sel, e);
      if (i >= 80)
         stop_test();
   endtask
   task automatic pulse;
      @(posedge clk);
      upd <= 1'h1;
      @(posedge clk);
      upd <= 1'h0;
      @(negedge clk);
   endtask
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      stop_test();
   end
   initial
   begin
      {rst_n, hsel, hwrite, lock, upd, osc, haddr, htrans} = '0;
      {hsize, hwdata, run0, run1} = {3'h2, 32'h0, 2'h3};
      n_fail = 0;
      comparisons = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      rchk("cfg", 12'h000, 32'h0);
      rchk("div", 12'h004, 32'h00010001);
      bus(1'h1, 12'h00C, 32'hFFFFFFFF);
      rchk("rsvd", 12'h00C, 32'h0);
      rchk("unmapped", 12'h010, 32'h0);
      chk("tune", tune, 1'h0);
      $display("test reset done");
      wcfg(9'h009);
      chk("select", sel, 1'h1);
      chk("kind", kind, 2'h2);
      wcfg(9'h004);
      @(posedge clk);
      run0 <= 1'h0;
      repeat (40) @(negedge clk);
      chk("select", sel, 1'h0);
      chk("kind", kind, 2'h1);
      chk("oe0", e0, 1'h0);
      run0 <= 1'h1;
      $display("test forced done");
      wcfg(9'h000);
      wcfg(9'h0C3);
      wsel(1'h0);
      run0 <= 1'h0;
      wsel(1'h1);
      chk("oe0", e0, 1'h1);
      chk("o0", o0, 1'h1);
      rchk("stat", 12'h008, 32'h5);
      wcfg(9'h043);
      chk("nmos", {e0, e1, o1}, 3'h2);
      wcfg(9'h083);
      chk("pmos", {e0, o0, e1}, 3'h6);
      run0 <= 1'h1;
      wsel(1'h0);
      $display("test revertive done");
      wcfg(9'h000);
      wcfg(9'h0C2);
      wsel(1'h0);
      run0 <= 1'h0;
      wsel(1'h1);
      run0 <= 1'h1;
      repeat (40) @(negedge clk);
      chk("select", sel, 1'h1);
      run1 <= 1'h0;
      wsel(1'h0);
      run1 <= 1'h1;
      $display("test nonrevertive done");
      wcfg(9'h100);
      pulse();
      n = 0;
      repeat (10)
      begin
         @(negedge clk);
         n += tune;
      end
      chk("early tune", n, 0);
      @(posedge clk);
      lock <= 1'h1;
      i = 0;
      while (tune !== 1'h1 && i < 5)
      begin
         @(negedge clk);
         i++;
      end
      chk("late tune", tune, 1'h1);
      @(posedge clk);
      lock <= 1'h0;
      wcfg(9'h000);
      pulse();
      chk("tune", tune, 1'h1);
      n = 0;
      repeat (40)
      begin
         @(negedge clk);
         n += rtk;
      end
      chk("ref ticks", n > 0, 1'h1);
      $display("test tune done");
      bus(1'h1, 12'h004, 32'h00010003);
      rchk("div", 12'h004, 32'h00010003);
      osc <= 1'h1;
      i = 0;
      while (ftk !== 1'h1 && i < 20)
      begin
         @(negedge clk);
         i++;
      end
      i = 0;
      do
      begin
         @(negedge clk);
         i++;
      end
      while (ftk !== 1'h1 && i < 20);
      chk("fb spacing", i, 3);
      bus(1'h1, 12'h004, 32'h00010000);
      repeat (5) @(negedge clk);
      n = 0;
      repeat (20)
      begin
         @(negedge clk);
         n += ftk;
      end
      chk("zero ratio", n, 0);
      $display("test divider done");
      stop_test();
   end
endmodule
`default_nettype wire
